// ==== dv/timer_channel_pin_control_bench.sv ====
// register-level tests of the timer pins
`timescale 1ns/100ps
module timer_channel_pin_control_bench;
    logic clk_sys = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, cap, ext_clock_in;
    logic bready = 1'b1, rready = 1'b1; // responses always accepted
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, d, q, c = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf; // whole words only
    logic [1:0] bresp, rresp, r, channel_pin_out, channel_pin_oe, channel_pin_owned;
    wire logic fixed_clock_in = ext_clock_in; // fixed source borrows the slow pin clock
    // pin wire: unit drive where enabled, else pulses or pull-down
    wire logic [1:0] channel_pin_in = (channel_pin_oe & channel_pin_out) | {1'b0, cap};
    int miscompares = 0, compares = 0;
    int pwm_hi[4] = '{48, 96, 54, 90}; // high cycles in 144
    tpc_timer #(.N_CH(2)) dut (.*);
    tpc_pins_model pins (.clk_sys(clk_sys), .ext_clock_in(ext_clock_in), .cap(cap));
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) c <= c + channel_pin_out[1]; // high-cycle tally
    task results;
        $display("miscompares %0d compares %0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) $display("MISMATCH %0t got %h want %h", $time, g, e);
        miscompares += (g !== e);
    endtask
    // write: both channels offered, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask
    task wrs(input logic [39:0] s[4]);
        foreach (s[i]) wr(s[i][39:32], s[i][31:0]);
    endtask
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        r = rresp;
        q = rdata;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #200000;
        miscompares++;
        results;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        wrs('{40'h40_0000_0005, 40'h44_0000_0003, 40'h10_0000_0100, 40'h20_0000_000d});
        wr(8'h00, 32'h0000_0001);
        repeat (12) @(posedge clk_sys);
        chk({irq, channel_pin_out[0], channel_pin_oe[0]}, 3'b111);
        wr(8'h20, 32'h0000_0005);
        chk(channel_pin_out[0], 1'b1);
        wr(8'h08, 32'h0000_0008);
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, m < 2 ? 32'h0000_0001 : 32'h0000_0005);
            wr(8'h24, 32'h0000_000a | (m[0] << 2));
            repeat (40) @(posedge clk_sys);
            d = c;
            repeat (144) @(posedge clk_sys);
            chk(c - d, pwm_hi[m]);
        end
        chk(channel_pin_oe, 2'b11);
        wrs('{40'h00_0000_0000, 40'h0c_0000_0301, 40'h20_0000_0004, 40'h00_0000_0001});
        @(posedge clk_sys); // pin ownership lags the control write by one edge
        chk({irq, channel_pin_owned[0], channel_pin_oe[0]}, 3'b010);
        pins.send_pulse();
        repeat (6) @(posedge clk_sys);
        chk(irq, 1'b1);
        wrs('{40'h00_0000_0000, 40'h0c_0000_0301, 40'h20_0000_0001, 40'h00_0000_0003});
        chk({irq, channel_pin_owned[0]}, 2'b00);
        repeat (120) @(posedge clk_sys);
        chk(irq, 1'b1);
        // fixed source: stop, clear the flag, then count again
        wrs('{40'h00_0000_0000, 40'h0c_0000_0100, 40'h10_0000_0100, 40'h00_0000_0002});
        @(posedge clk_sys);
        chk(irq, 1'b0);
        repeat (120) @(posedge clk_sys);
        chk(irq, 1'b1);
        rd(8'h18);
        chk(r, tpc_pkg::RESP_SLVERR);
        chk(q, 32'h0000_0000);
        rd(8'h20);
        chk(q, 32'h0000_0001);
        wr(8'h18, 32'h0000_0000);
        chk(r, tpc_pkg::RESP_SLVERR);
        results;
    end
endmodule

// ==== dv/tpc_pins_model.sv ====
// far-side pin model: external counter clock and capture pulses
`timescale 1ns/100ps
module tpc_pins_model (
    input wire logic clk_sys,
    output logic ext_clock_in,
    output logic cap
);
    logic [2:0] div = 3'h0; // free-running divider, the clock pin never stops
    initial cap = 1'b0;
    // one eighth of bus rate keeps margin under the quarter-rate limit
    always @(posedge clk_sys) div <= div + 3'h1;
    assign ext_clock_in = div[2];
    // pulse held four bus clocks, the shortest that is reliably seen
    task send_pulse;
        cap <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cap <= 1'b0;
    endtask
endmodule

// ==== dv/tpc_timer_chk.sv ====
// bus handshake and pin ownership assertions for the timer
`timescale 1ns/100ps
module tpc_timer_chk #(parameter int N_CH = 2) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [N_CH-1:0] channel_pin_oe,
    input wire logic [N_CH-1:0] channel_pin_owned
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    own_drive_a: assert property ((channel_pin_oe & ~channel_pin_owned) == '0)
        else $error("oe");
    // address and data are held first, the response flop follows an edge later
    b_follows_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("b");
    b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bh");
    b_done_a: assert property (bvalid && bready |=> !bvalid ##0 awready) else $error("bd");
    aw_block_a: assert property (bvalid |-> !awready && !wready) else $error("aw");
    r_follows_a: assert property (arvalid && arready |=> rvalid) else $error("r");
    r_hold_a: assert property (rvalid && !rready |=> rvalid) else $error("rh");
    ar_block_a: assert property (rvalid |-> !arready) else $error("ar");
    cover property (bvalid && bready);
    cover property (rvalid && rready);
    cover property (channel_pin_oe == '1);
endmodule
bind tpc_timer tpc_timer_chk #(.N_CH(N_CH)) chk_i (.*);

// ==== rtl/tpc_pkg.sv ====
// shared constants and types for the timer channel pin control block
// Overview of operation
// - clock select: off, bus, fixed, external
// - external clock synchronised; max quarter bus rate
// - external clock allows output compare software timer
// - pin released when edge select or clock off
// - center-aligned mode drives every active channel
// - mode bits pick capture, compare or pwm
// - capture forces input; edge select picks polarity
// - capture edges synchronised; pulses four bus clocks
// - compare drives pin, acts on counter match
// - toggle keeps previous pin until next match
// - edge pwm drives output; low bit sets polarity
// - high-true pwm: high at zero, low on match
// - low-true pwm: low at zero, high on match
// - center high-true: clear up-match, set down-match
// - center low-true: set up-match, clear down-match
// - one to eight channels, several instances allowed
// - center mode counts up to modulo, down to zero
package tpc_pkg;
    // bus clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAPTURE_MIN_PULSE_NS = 200;
    localparam int CAPTURE_MIN_PULSE_CYC =
        (CAPTURE_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_CLOCK_MIN_PERIOD_CYC = 4;
    localparam int MAX_CHANNELS = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_MODULO = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_PINS = 8'h14;
    localparam logic [7:0] OFS_CH_CTRL = 8'h20;
    localparam logic [7:0] OFS_CH_VALUE = 8'h40;

    // field positions
    localparam int CTRL_CLK_SEL_LSB = 0;
    localparam int CTRL_CENTER_BIT = 2;
    localparam int CTRL_PRESCALE_LSB = 3;
    localparam int CHC_MODE_LSB = 0;
    localparam int CHC_ELS_LSB = 2;
    localparam int STAT_OVERFLOW_BIT = 0;
    localparam int STAT_CH_LSB = 8;
    localparam int PINS_OE_LSB = 8;
    localparam int PINS_IN_LSB = 16;

    // codes and reset values
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_BUS = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // module-wide control word
    typedef struct packed {
        logic [2:0] prescale;
        logic center_aligned_mode;
        logic [1:0] clock_source_select;
    } tpc_ctrl_s;

    // per channel control word
    typedef struct packed {
        logic [1:0] edge_level_select;
        logic [1:0] channel_mode_select;
    } tpc_ch_cfg_s;
endpackage

// ==== rtl/tpc_sync_edge.sv ====
// two-stage synchroniser with edge detection for one pin input
`timescale 1ns/100ps
module tpc_sync_edge (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1; // metastable catcher, read only by stage2
    logic stage2; // safe synchronised level
    logic stage3; // previous synchronised level

    // shift chain; edges only ever look at stage2 and stage3
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule

// ==== rtl/tpc_timer.sv ====
// timer/pwm unit: counter, channels, pin control and axi4-lite registers
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module tpc_timer #(
    parameter int N_CH = 2 // channel count, 1 to 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    // axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // clock pins
    input wire logic ext_clock_in,
    input wire logic fixed_clock_in,
    // channel pins and interrupt
    input wire logic [N_CH-1:0] channel_pin_in,
    output logic [N_CH-1:0] channel_pin_out,
    output logic [N_CH-1:0] channel_pin_oe,
    output logic [N_CH-1:0] channel_pin_owned,
    output logic irq
);
    // mask of prescaler low bits for divide by 2**ps
    function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
        prescale_mask = 7'((8'h01 << ps) - 8'h01);
    endfunction

    // map a byte address to a channel slot, valid flag on top
    function automatic logic [3:0] ch_slot(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        ch_slot = {(addr >= base) && (rel < 8'(4 * N_CH)) && (rel[1:0] == 2'h0), rel[4:2]};
    endfunction

    // merge written bytes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction

    // register state
    tpc_pkg::tpc_ctrl_s ctrl; // module-wide control
    logic [15:0] modulo_value; // counter modulo
    logic [15:0] timer_counter; // the 16-bit counter
    logic count_up; // direction in center mode
    logic [6:0] pre_cnt; // prescaler count
    logic cnt_upd; // counter changed last edge
    logic [31:0] status; // sticky events
    logic [31:0] irq_mask; // interrupt enables
    tpc_pkg::tpc_ch_cfg_s ch_cfg [tpc_pkg::MAX_CHANNELS]; // channel control
    logic [15:0] ch_val [tpc_pkg::MAX_CHANNELS]; // channel values

    // bus handshake state
    logic aw_have; // write address held
    logic w_have; // write data held
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_en; // commit a held write
    logic wr_unmapped;

    // synchronised pins
    logic ext_rise; // external clock edge
    logic fix_rise; // fixed clock edge
    logic [N_CH-1:0] pin_lvl;
    logic [N_CH-1:0] pin_rise;
    logic [N_CH-1:0] pin_fall;

    // decoded counter and per-channel events
    logic tick; // prescaler input tick
    logic step; // counter advances
    logic overflow; // period end
    logic [N_CH-1:0] match_hit; // compare match this cycle
    logic [N_CH-1:0] cap_hit; // capture edge this cycle
    logic [N_CH-1:0] ch_event; // flag set for channel
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [3:0] wr_ctrl_slot;
    logic [3:0] wr_val_slot;

    // external clock through the bus-clocked synchroniser
    tpc_sync_edge u_ext_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(ext_clock_in),
        .level(),
        .rise(ext_rise),
        .fall()
    );

    // fixed clock domain brought onto the bus clock
    tpc_sync_edge u_fix_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(fixed_clock_in),
        .level(),
        .rise(fix_rise),
        .fall()
    );

    // capture pins synchronised before edge sensing
    for (genvar g = 0; g < N_CH; g++) begin : g_pin
        tpc_sync_edge u_pin_sync (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .async_in(channel_pin_in[g]),
            .level(pin_lvl[g]),
            .rise(pin_rise[g]),
            .fall(pin_fall[g])
        );
    end

    // ---------------- axi4-lite write path ----------------
    assign wr_en = aw_have & w_have & ~bvalid;
    assign wr_ctrl_slot = ch_slot(wr_addr, tpc_pkg::OFS_CH_CTRL);
    assign wr_val_slot = ch_slot(wr_addr, tpc_pkg::OFS_CH_VALUE);
    assign wr_unmapped = !(wr_addr == tpc_pkg::OFS_CTRL || wr_addr == tpc_pkg::OFS_COUNT ||
                           wr_addr == tpc_pkg::OFS_MODULO || wr_addr == tpc_pkg::OFS_STATUS ||
                           wr_addr == tpc_pkg::OFS_MASK || wr_addr == tpc_pkg::OFS_PINS ||
                           wr_ctrl_slot[3] || wr_val_slot[3]);

    // address and data taken in either order, response after both
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= tpc_pkg::RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                aw_have <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
                w_have <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_en) begin
                // unmapped address answers slave error; a write to the read-only pins register answers okay
                aw_have <= 1'b0;
                w_have <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_unmapped ? tpc_pkg::RESP_SLVERR : tpc_pkg::RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ---------------- axi4-lite read path ----------------
    // one word answered on the same edge that takes the address
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= tpc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= tpc_pkg::RESP_OKAY;
            if (araddr == tpc_pkg::OFS_CTRL) begin
                rdata <= {26'h000_0000, ctrl};
            end else if (araddr == tpc_pkg::OFS_COUNT) begin
                rdata <= {16'h0000, timer_counter};
            end else if (araddr == tpc_pkg::OFS_MODULO) begin
                rdata <= {16'h0000, modulo_value};
            end else if (araddr == tpc_pkg::OFS_STATUS) begin
                rdata <= status;
            end else if (araddr == tpc_pkg::OFS_MASK) begin
                rdata <= irq_mask;
            end else if (araddr == tpc_pkg::OFS_PINS) begin
                rdata <= 32'h0000_0000;
                rdata[N_CH-1:0] <= channel_pin_out;
                rdata[tpc_pkg::PINS_OE_LSB +: N_CH] <= channel_pin_oe;
                rdata[tpc_pkg::PINS_IN_LSB +: N_CH] <= pin_lvl;
            end else if (ch_slot(araddr, tpc_pkg::OFS_CH_CTRL) >= 4'h8) begin
                // slot index only; the top bit is the hit flag
                rdata <= {28'h000_0000, ch_cfg[3'(ch_slot(araddr, tpc_pkg::OFS_CH_CTRL))]};
            end else if (ch_slot(araddr, tpc_pkg::OFS_CH_VALUE) >= 4'h8) begin
                rdata <= {16'h0000, ch_val[3'(ch_slot(araddr, tpc_pkg::OFS_CH_VALUE))]};
            end else begin
                // unmapped read returns zero with an error
                rdata <= 32'h0000_0000;
                rresp <= tpc_pkg::RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---------------- control registers ----------------
    // configuration written by software; channel slots above N_CH stay zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= '0;
            modulo_value <= tpc_pkg::MODULO_RESET;
            irq_mask <= 32'h0000_0000;
            for (int i = 0; i < tpc_pkg::MAX_CHANNELS; i++) begin
                ch_cfg[i] <= '0;
            end
        end else if (wr_en) begin
            if (wr_addr == tpc_pkg::OFS_CTRL && wr_strb[0]) begin
                ctrl <= wr_data[5:0];
            end
            if (wr_addr == tpc_pkg::OFS_MODULO) begin
                modulo_value <= 16'(merge({16'h0000, modulo_value}, wr_data, wr_strb));
            end
            if (wr_addr == tpc_pkg::OFS_MASK) begin
                irq_mask <= merge(irq_mask, wr_data, wr_strb);
            end
            if (wr_ctrl_slot[3] && wr_strb[0]) begin
                ch_cfg[wr_ctrl_slot[2:0]] <= wr_data[3:0];
            end
        end
    end

    // ---------------- counter ----------------
    // clock source choice feeds the prescaler; off means no ticks
    always_comb begin
        unique case (ctrl.clock_source_select)
            tpc_pkg::CLK_OFF: tick = 1'b0;
            tpc_pkg::CLK_BUS: tick = 1'b1;
            tpc_pkg::CLK_FIXED: tick = fix_rise;
            tpc_pkg::CLK_EXT: tick = ext_rise;
        endcase
    end

    assign step = tick && ((pre_cnt & prescale_mask(ctrl.prescale)) ==
                           prescale_mask(ctrl.prescale));

    // free-running or modulo up count, up/down in center mode; any count write clears
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timer_counter <= tpc_pkg::COUNT_RESET;
            pre_cnt <= 7'h00;
            count_up <= 1'b1;
            cnt_upd <= 1'b0;
            overflow <= 1'b0;
        end else begin
            cnt_upd <= step;
            overflow <= 1'b0;
            if (wr_en && wr_addr == tpc_pkg::OFS_COUNT) begin
                timer_counter <= tpc_pkg::COUNT_RESET;
                pre_cnt <= 7'h00;
                count_up <= 1'b1;
            end else begin
                if (tick) begin
                    pre_cnt <= pre_cnt + 7'h01;
                end
                if (step && ctrl.center_aligned_mode) begin
                    // turn at modulo, turn again at zero
                    if (count_up && timer_counter >= modulo_value) begin
                        count_up <= 1'b0;
                        timer_counter <= (timer_counter == 16'h0000) ? 16'h0000 :
                                         timer_counter - 16'h0001;
                    end else if (count_up) begin
                        timer_counter <= timer_counter + 16'h0001;
                    end else if (timer_counter <= 16'h0001) begin
                        count_up <= 1'b1;
                        timer_counter <= tpc_pkg::COUNT_RESET;
                        overflow <= 1'b1;
                    end else begin
                        timer_counter <= timer_counter - 16'h0001;
                    end
                end else if (step) begin
                    // modulo 0 or all ones runs free through the full range
                    count_up <= 1'b1;
                    if ((modulo_value != 16'h0000 && timer_counter >= modulo_value) ||
                        timer_counter == tpc_pkg::COUNT_MAX) begin
                        timer_counter <= tpc_pkg::COUNT_RESET;
                        overflow <= 1'b1;
                    end else begin
                        timer_counter <= timer_counter + 16'h0001;
                    end
                end
            end
        end
    end

    // ---------------- channel decode ----------------
    // matches seen once per counter change; capture edges per edge select
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            match_hit[i] = cnt_upd && (timer_counter == ch_val[i]);
            cap_hit[i] = !ctrl.center_aligned_mode &&
                         ch_cfg[i].channel_mode_select == tpc_pkg::MODE_CAPTURE &&
                         ctrl.clock_source_select != tpc_pkg::CLK_OFF &&
                         ((ch_cfg[i].edge_level_select[0] && pin_rise[i]) ||
                          (ch_cfg[i].edge_level_select[1] && pin_fall[i]));
            // compare flags still run with edge select zero as a software timer
            ch_event[i] = cap_hit[i] || (match_hit[i] && (ctrl.center_aligned_mode ||
                          ch_cfg[i].channel_mode_select != tpc_pkg::MODE_CAPTURE));
        end
    end

    // channel values: software writes, capture loads the counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < tpc_pkg::MAX_CHANNELS; i++) begin
                ch_val[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < N_CH; i++) begin
                if (cap_hit[i]) begin
                    ch_val[i] <= timer_counter;
                end else if (wr_en && wr_val_slot[3] && wr_val_slot[2:0] == 3'(i)) begin
                    ch_val[i] <= 16'(merge({16'h0000, ch_val[i]}, wr_data, wr_strb));
                end
            end
        end
    end

    // ---------------- pin control ----------------
    // one process for all pin state; ownership, direction and level all registered
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channel_pin_out <= '0;
            channel_pin_oe <= '0;
            channel_pin_owned <= '0;
        end else begin
            for (int i = 0; i < N_CH; i++) begin
                // released to port control when edge select or clock is off
                channel_pin_owned[i] <= ch_cfg[i].edge_level_select != tpc_pkg::ELS_NONE &&
                                        ctrl.clock_source_select != tpc_pkg::CLK_OFF;
                // capture keeps the pin an input; every other mode drives it
                channel_pin_oe[i] <= ch_cfg[i].edge_level_select != tpc_pkg::ELS_NONE &&
                                     ctrl.clock_source_select != tpc_pkg::CLK_OFF &&
                                     (ctrl.center_aligned_mode ||
                                      ch_cfg[i].channel_mode_select != tpc_pkg::MODE_CAPTURE);
                if (ch_cfg[i].edge_level_select == tpc_pkg::ELS_NONE) begin
                    // no pin action; level kept for a later toggle start
                    channel_pin_out[i] <= channel_pin_out[i];
                end else if (ctrl.center_aligned_mode) begin
                    // low select bit flips the polarity of both match actions
                    if (match_hit[i]) begin
                        channel_pin_out[i] <= count_up ? ch_cfg[i].edge_level_select[0] :
                                                         !ch_cfg[i].edge_level_select[0];
                    end
                end else if (ch_cfg[i].channel_mode_select[1]) begin
                    // edge pwm: match wins over period start so value 0 gives 0% duty
                    if (match_hit[i]) begin
                        channel_pin_out[i] <= ch_cfg[i].edge_level_select[0];
                    end else if (cnt_upd && timer_counter == tpc_pkg::COUNT_RESET) begin
                        channel_pin_out[i] <= !ch_cfg[i].edge_level_select[0];
                    end
                end else if (ch_cfg[i].channel_mode_select == tpc_pkg::MODE_COMPARE) begin
                    // previous level stands until the first match
                    if (match_hit[i]) begin
                        unique case (ch_cfg[i].edge_level_select)
                            tpc_pkg::ELS_TOGGLE: channel_pin_out[i] <= !channel_pin_out[i];
                            tpc_pkg::ELS_CLEAR: channel_pin_out[i] <= 1'b0;
                            tpc_pkg::ELS_SET: channel_pin_out[i] <= 1'b1;
                            default: channel_pin_out[i] <= channel_pin_out[i];
                        endcase
                    end
                end
            end
        end
    end

    // ---------------- events and interrupt ----------------
    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[tpc_pkg::STAT_OVERFLOW_BIT] = overflow;
        set_bits[tpc_pkg::STAT_CH_LSB +: N_CH] = ch_event;
        clr_bits = (wr_en && wr_addr == tpc_pkg::OFS_STATUS) ?
                   merge(32'h0000_0000, wr_data, wr_strb) : 32'h0000_0000;
    end

    // sticky flags, write one clears; a new event in the clear cycle survives
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status <= 32'h0000_0000;
        end else begin
            status <= (status & ~clr_bits) | set_bits;
        end
    end

    // level interrupt from a flop, one cycle behind the flags
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & irq_mask);
        end
    end
endmodule
